/* File: dv/pulse_sink.sv */
// partner model: load on one pulse pin, measures period and high time in clocks
// assumes the pin is sampled on the system clock edge, like a synchronous counter
`timescale 1ns/1ps
`default_nettype none
module pulse_sink (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic pulse_in,
	output var int rises,
	output var int period,
	output var int high_time
);
	logic prev_ff;
	int cnt_ff;
	int hc_ff;
	// a rise closes a period; the first one after enable may be partial
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prev_ff <= 1'b0;
			cnt_ff <= 0;
			hc_ff <= 0;
			rises <= 0;
			period <= 0;
			high_time <= 0;
		end else begin
			prev_ff <= pulse_in;
			if (pulse_in && !prev_ff) begin
				rises <= rises + 1;
				period <= cnt_ff;
				high_time <= hc_ff;
				cnt_ff <= 1;
				hc_ff <= 1;
			end else begin
				cnt_ff <= cnt_ff + 1;
				hc_ff <= hc_ff + int'(pulse_in);
			end
		end
	end
endmodule // pulse_sink
`default_nettype wire

/* File: dv/test_dual_channel_pwm.sv */
// bench: register access over avalon-mm, then pulse timing on both pins
// assumes pulse_sink on each pin and one 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_dual_channel_pwm import pwm_pkg::*;;
	logic sys_clk = 0, nrst = 0, clk_en = 1, read = 0, write = 0;
	logic [ADDR_W-1:0] address = '0;
	logic [31:0] writedata = '0, readdata, seed = 32'h0000_0a43, q, v;
	logic [3:0] byteenable = 4'hf;
	logic waitrequest, pulse_out_0, pulse_out_1;
	logic [7:0] regs [6], last [6], rl, hc;
	logic [2:0] sl;
	int err_total = 0, checks = 0, cyc = 0, r0, r1, p0, p1, h0, h1, b0, b1, n;
	always #4 sys_clk = ~sys_clk;
	dual_channel_pwm DUT (.sys_clk, .nrst, .clk_en, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .pulse_out_0, .pulse_out_1);
	pulse_sink s0 (.sys_clk, .nrst, .pulse_in(pulse_out_0), .rises(r0), .period(p0), .high_time(h0));
	pulse_sink s1 (.sys_clk, .nrst, .pulse_in(pulse_out_1), .rises(r1), .period(p1), .high_time(h1));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// clocks per span of counts, divide codes above 5 act as the slowest
	function automatic int exp_span(input logic [7:0] from, input int s);
		return (256 - int'(from)) * (2 << (s > 5 ? 5 : s));
	endfunction
	// high time: the match tick raises the pin, the tick at 8'hff drops it, so one tick fewer than a span
	function automatic int exp_high(input logic [7:0] from, input int s);
		return (255 - int'(from)) * (2 << (s > 5 ? 5 : s));
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// one avalon transfer; held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		k = 0;
		address <= {idx, 2'b00};
		write <= w;
		read <= !w;
		writedata <= {24'h00_0000, d};
		do begin
			@(posedge sys_clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 40);
		q = readdata;
		if (k >= 40) err_total++;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard: eight timing runs need well under this
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		regs = '{IDX_CHAN0_CONTROL, IDX_CHAN0_HIGH_COMPARE, IDX_CHAN0_RELOAD,
			IDX_CHAN1_CONTROL, IDX_CHAN1_HIGH_COMPARE, IDX_CHAN1_RELOAD};
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		foreach (regs[i]) begin
			bus(0, regs[i], 8'h00);
			chk(q, 32'h0000_0000, "reset value");
		end
		bus(0, 8'h00_A8, 8'h00);
		chk(q, UNMAPPED_READ, "unmapped");
		$display("test reset done");
		// random read-back; unused control bits must read zero
		foreach (regs[i]) begin
			v = rnd();
			last[i] = (i % 3 == 0) ? v[7:0] & CONTROL_USED_MASK : v[7:0];
			bus(1, regs[i], v[7:0]);
			bus(0, regs[i], 8'h00);
			chk(q, {24'h00_0000, last[i]}, "read back");
		end
		byteenable <= 4'h0;
		bus(1, regs[1], ~last[1]);
		bus(0, regs[1], 8'h00);
		chk(q, {24'h00_0000, last[1]}, "lane off");
		// restore the low lane, or every later write would be dropped
		byteenable <= 4'hf;
		bus(1, regs[0], 8'h00);
		bus(1, regs[3], 8'h00);
		b0 = r0;
		repeat (300) @(posedge sys_clk);
		chk({pulse_out_1, pulse_out_0}, 2'b00, "idle pins");
		chk(r0 - b0, 0, "idle rises");
		$display("test registers done");
		// every divide code, channel 1 runs the mirrored code at once
		for (int s = 0; s < 8; s++) begin
			v = rnd();
			rl = (s == 1) ? 8'h00 : (8'hE0 | {4'h0, v[3:0]});
			hc = 8'hFE - ((8'hFE - rl) & {3'h0, v[12:8]});
			if (s == 0) hc = rl;
			sl = s[2:0];
			bus(1, regs[2], rl);
			bus(1, regs[1], hc);
			bus(1, regs[5], rl | 8'hE0);
			bus(1, regs[4], hc | 8'hE0);
			bus(1, regs[0], {5'h10, sl});
			bus(1, regs[3], {5'h10, ~sl});
			b0 = r0;
			b1 = r1;
			n = 0;
			while ((r0 < b0 + 3 || r1 < b1 + 3) && n < 30000) begin
				@(posedge sys_clk);
				n++;
			end
			chk(p0, exp_span(rl, s), "period 0");
			chk(h0, exp_high(hc, s), "high 0");
			chk(p1, exp_span(rl | 8'hE0, 7 - s), "period 1");
			chk(h1, exp_high(hc | 8'hE0, 7 - s), "high 1");
			bus(1, regs[0], 8'h00);
			bus(1, regs[3], 8'h00);
			repeat (3) @(posedge sys_clk);
			chk({pulse_out_1, pulse_out_0}, 2'b00, "off pins");
			$display("test divide %0d done", s);
		end
		end_sim();
	end
endmodule // test_dual_channel_pwm
`default_nettype wire

/* File: rtl/clk_divider.sv */
// tick generator: free-running prescaler, one-cycle tick per selected division
// assumes a single clock domain and a select from registered state
`timescale 1ns/1ps
`default_nettype none
module clk_divider
	import pwm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic [2:0] divide_sel,
	output logic tick
);
	logic [PRESCALE_W-1:0] pre_ff;
	logic [PRESCALE_W-1:0] nxt_pre;
	logic [PRESCALE_W-1:0] mask;

	// codes 110 and 111 fall back to /64 so the counter never loses its clock
	always_comb begin
		nxt_pre = pre_ff + 6'h01;
		case (divide_sel)
			3'h0: mask = 6'h01;
			3'h1: mask = 6'h03;
			3'h2: mask = 6'h07;
			3'h3: mask = 6'h0F;
			3'h4: mask = 6'h1F;
			default: mask = 6'h3F;
		endcase
		tick = ((pre_ff & mask) == mask);
	end

	// prescaler
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pre_ff <= '0;
		end else if (clk_en) begin
			pre_ff <= nxt_pre;
		end
	end
endmodule // clk_divider
`default_nettype wire

/* File: rtl/dual_channel_pwm.sv */
// top of the dual channel pulse generator: avalon-mm register file and two channels
// assumes a same-clock avalon-mm master; pulse outputs drive pins directly
// Notes on behaviour
// - each counter counts upward once per tick of its divided clock
// - counters have no bus path; only the control register steers them
// - enable set to one starts counting from the current value
// - enable zero halts the counter and loads it with the reload value
// - select codes 000 to 101 divide the clock by 2 through 64
// - an 8-bit read-write high-compare register sets the duty cycle
// - an 8-bit read-write reload register sets the period
// - enable bit sits at bit 7 of the control register
// - divide select occupies bits 2:0; bits 6:3 unused
// - two identical channels with their own registers, all reset to zero
// - counter and comparator are 8 bits wide
// - while enabled, counter equal to high-compare drives the output high; at 8'hFF the overflow wins and the output stays low
// - on overflow the output goes low and the counter reloads
// - while disabled the output is held low
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module dual_channel_pwm
	import pwm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic pulse_out_0,
	output logic pulse_out_1
);
	logic [7:0] control_ff [NUM_CHAN];
	logic [7:0] high_ff [NUM_CHAN];
	logic [7:0] reload_ff [NUM_CHAN];
	logic [7:0] nxt_control [NUM_CHAN];
	logic [7:0] nxt_high [NUM_CHAN];
	logic [7:0] nxt_reload [NUM_CHAN];
	logic ack_ff;
	logic nxt_ack;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [7:0] word_idx;
	logic word_ok;
	logic [NUM_CHAN-1:0] pulse;
	logic out0_ff;
	logic out1_ff;

	// byte address = index * 4; the low two address bits must be zero for a hit
	assign word_idx = address[ADDR_W-1:2];
	assign word_ok = (address[1:0] == 2'h0);

	// one wait state: the request is answered on the cycle after it is seen
	always_comb begin
		nxt_ack = (read || write) && !ack_ff;
		nxt_rdata = rdata_ff;
		for (int c = 0; c < NUM_CHAN; c++) begin
			nxt_control[c] = control_ff[c];
			nxt_high[c] = high_ff[c];
			nxt_reload[c] = reload_ff[c];
		end
		if (read && !ack_ff) begin
			nxt_rdata = UNMAPPED_READ; // unmapped reads answer zero
			if (word_ok) begin
				case (word_idx)
					IDX_CHAN0_CONTROL: nxt_rdata = {24'h00_0000, control_ff[0]};
					IDX_CHAN0_HIGH_COMPARE: nxt_rdata = {24'h00_0000, high_ff[0]};
					IDX_CHAN0_RELOAD: nxt_rdata = {24'h00_0000, reload_ff[0]};
					IDX_CHAN1_CONTROL: nxt_rdata = {24'h00_0000, control_ff[1]};
					IDX_CHAN1_HIGH_COMPARE: nxt_rdata = {24'h00_0000, high_ff[1]};
					IDX_CHAN1_RELOAD: nxt_rdata = {24'h00_0000, reload_ff[1]};
					default: nxt_rdata = UNMAPPED_READ;
				endcase
			end
		end
		// writes land at the edge that ends the wait; counters have no address
		if (write && ack_ff && word_ok && byteenable[0]) begin
			case (word_idx)
				IDX_CHAN0_CONTROL: nxt_control[0] = writedata[7:0] & CONTROL_USED_MASK;
				IDX_CHAN0_HIGH_COMPARE: nxt_high[0] = writedata[7:0];
				IDX_CHAN0_RELOAD: nxt_reload[0] = writedata[7:0];
				IDX_CHAN1_CONTROL: nxt_control[1] = writedata[7:0] & CONTROL_USED_MASK;
				IDX_CHAN1_HIGH_COMPARE: nxt_high[1] = writedata[7:0];
				IDX_CHAN1_RELOAD: nxt_reload[1] = writedata[7:0];
				default: nxt_rdata = rdata_ff; // unmapped writes are dropped
			endcase
		end
	end

	// register file, all zero after reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				control_ff[c] <= CONTROL_RESET;
				high_ff[c] <= HIGH_COMPARE_RESET;
				reload_ff[c] <= RELOAD_RESET;
			end
			ack_ff <= 1'b0;
			rdata_ff <= UNMAPPED_READ;
		end else if (clk_en) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				control_ff[c] <= nxt_control[c];
				high_ff[c] <= nxt_high[c];
				reload_ff[c] <= nxt_reload[c];
			end
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	// waitrequest is low only in the answer cycle; a registered flop keeps it glitch free
	logic wait_ff;
	logic nxt_wait;
	always_comb begin
		nxt_wait = !nxt_ack;
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wait_ff <= 1'b1;
		end else if (clk_en) begin
			wait_ff <= nxt_wait;
		end
	end
	assign waitrequest = wait_ff;
	assign readdata = rdata_ff;

	// two identical channels, 8-bit counters
	for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
		pwm_channel u_chan (
			.sys_clk(sys_clk),
			.nrst(nrst),
			.clk_en(clk_en),
			.enable(control_ff[g][ENABLE_POS]),
			.divide_sel(control_ff[g][SEL_HI:SEL_LO]),
			.high_compare_value(high_ff[g]),
			.reload_value(reload_ff[g]),
			.pulse_out(pulse[g])
		);
	end

	// pins come from the channel flops already; kept as names for the ports
	assign out0_ff = pulse[0];
	assign out1_ff = pulse[1];
	assign pulse_out_0 = out0_ff;
	assign pulse_out_1 = out1_ff;

	property p_wait_one;
		@(posedge sys_clk) disable iff (!nrst) (clk_en && read && waitrequest) |=> !waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("read not answered after one wait");

	property p_ctrl_write;
		@(posedge sys_clk) disable iff (!nrst)
			(clk_en && write && !waitrequest && address == 10'h2A4 && byteenable[0])
			|=> (control_ff[0] == ($past(writedata[7:0]) & CONTROL_USED_MASK));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

	property p_high_read;
		@(posedge sys_clk) disable iff (!nrst)
			(clk_en && read && waitrequest && address == 10'h2A8) |=> (readdata == {24'h00_0000, high_ff[0]});
	endproperty
	a_high_read: assert property (p_high_read) else $error("high-compare read wrong");

	property p_enable_zero_out;
		@(posedge sys_clk) disable iff (!nrst) (!control_ff[1][ENABLE_POS]) ##1 (!control_ff[1][ENABLE_POS]) |-> !pulse_out_1;
	endproperty
	a_enable_zero_out: assert property (p_enable_zero_out) else $error("channel 1 out high while disabled");
endmodule // dual_channel_pwm
`default_nettype wire

/* File: rtl/pwm_channel.sv */
// one pulse channel: 8-bit up counter, compare sets high, overflow clears and reloads
// assumes control values from the register file on the same clock
`timescale 1ns/1ps
`default_nettype none
module pwm_channel
	import pwm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic enable,
	input wire logic [2:0] divide_sel,
	input wire logic [CNT_W-1:0] high_compare_value,
	input wire logic [CNT_W-1:0] reload_value,
	output logic pulse_out
);
	logic tick;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic out_ff;
	logic nxt_out;

	clk_divider u_div (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.divide_sel(divide_sel),
		.tick(tick)
	);

	// counter and output: disabled holds reload and low; overflow wins over a match
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_out = out_ff;
		if (!enable) begin
			nxt_cnt = reload_value;
			nxt_out = 1'b0;
		end else if (tick) begin
			if (cnt_ff == 8'hFF) begin
				nxt_cnt = reload_value;
				nxt_out = 1'b0;
			end else begin
				nxt_cnt = cnt_ff + 8'h01;
				if (cnt_ff == high_compare_value) begin
					nxt_out = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= RELOAD_RESET;
			out_ff <= 1'b0;
		end else if (clk_en) begin
			cnt_ff <= nxt_cnt;
			out_ff <= nxt_out;
		end
	end

	assign pulse_out = out_ff;

	property p_disabled_low;
		@(posedge sys_clk) disable iff (!nrst) (clk_en && !enable) |=> !out_ff;
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("output high while disabled");

	property p_disabled_reload;
		@(posedge sys_clk) disable iff (!nrst) (clk_en && !enable) |=> (cnt_ff == $past(reload_value));
	endproperty
	a_disabled_reload: assert property (p_disabled_reload) else $error("counter not reloaded while disabled");

	sequence s_count_step;
		clk_en && enable && tick && cnt_ff != 8'hFF;
	endsequence
	property p_count_up;
		@(posedge sys_clk) disable iff (!nrst) s_count_step |=> (cnt_ff == $past(cnt_ff) + 8'h01);
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter did not step up");

	property p_no_tick_hold;
		@(posedge sys_clk) disable iff (!nrst) (clk_en && enable && !tick) |=> $stable(cnt_ff);
	endproperty
	a_no_tick_hold: assert property (p_no_tick_hold) else $error("counter moved without tick");

	property p_match_high;
		@(posedge sys_clk) disable iff (!nrst)
			(s_count_step and (cnt_ff == high_compare_value)) |=> out_ff;
	endproperty
	a_match_high: assert property (p_match_high) else $error("no high on match");

	property p_overflow;
		@(posedge sys_clk) disable iff (!nrst)
			(clk_en && enable && tick && cnt_ff == 8'hFF) |=> (!out_ff && cnt_ff == $past(reload_value));
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow did not reload and clear");

	property p_div2;
		@(posedge sys_clk) disable iff (!nrst)
			(clk_en && divide_sel == 3'h0 && tick) ##1 (clk_en && divide_sel == 3'h0) |-> !tick;
	endproperty
	a_div2: assert property (p_div2) else $error("divide by two ticks back to back");

	property p_div64;
		@(posedge sys_clk) disable iff (!nrst) (divide_sel == 3'h7 && tick) |-> (u_div.pre_ff == 6'h3F);
	endproperty
	a_div64: assert property (p_div64) else $error("undefined code not divide by 64");
endmodule // pwm_channel
`default_nettype wire

/* File: rtl/pwm_pkg.sv */
// package for the dual channel pulse generator: register map, field layout, reset values
// assumes a 32-bit avalon-mm slave; each register takes one aligned word
package pwm_pkg;
	// printed offsets are not all multiples of four: they are register indices
	localparam logic [7:0] IDX_CHAN0_CONTROL = 8'h00_A9;
	localparam logic [7:0] IDX_CHAN0_HIGH_COMPARE = 8'h00_AA;
	localparam logic [7:0] IDX_CHAN0_RELOAD = 8'h00_AB;
	localparam logic [7:0] IDX_CHAN1_CONTROL = 8'h00_B0;
	localparam logic [7:0] IDX_CHAN1_HIGH_COMPARE = 8'h00_B1;
	localparam logic [7:0] IDX_CHAN1_RELOAD = 8'h00_B2;
	localparam int ADDR_W = 10;
	localparam int NUM_CHAN = 2;
	localparam int CNT_W = 8;
	localparam int ENABLE_POS = 7;
	localparam int SEL_HI = 2;
	localparam int SEL_LO = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00_00;
	localparam logic [7:0] HIGH_COMPARE_RESET = 8'h00_00;
	localparam logic [7:0] RELOAD_RESET = 8'h00_00;
	localparam logic [7:0] CONTROL_USED_MASK = 8'h00_87;
	localparam logic [2:0] SEL_DIV64 = 3'h5;
	localparam int PRESCALE_W = 6;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : pwm_pkg
